/* File: src/tws_trigger_wait.v */
// trigger wait indicators, overtrigger flags and output line routing
// What this block does
// - frame wait rises on entering frame waiting
// - frame wait falls when frame pulse accepted
// - frame pulse while busy: discard, flag overtrigger
// - frame wait only with hardware frame trigger
// - timed mode: rise from exposure and readout
// - width mode: rise from floor and readout
// - rolling: rise after exposure plus minimum line interval
// - acquisition wait selectable as line source
// - frame wait selectable as line source
// - line one output, gpio lines need output direction
// - acquisition wait rises on waiting, falls accepted
// - acquisition pulse while busy: discard, flag overtrigger
// - acquisition wait only with hardware acquisition trigger
`timescale 1ns/10ps
`include "tws_defines.vh"
module tws_trigger_wait (
    clk,
    rst,
    hw_frame_start_pulse,
    ext_acq_start_pulse,
    frame_hw_trig_en,
    acq_hw_trig_en,
    acq_active,
    exposure_mode,
    exposure_duration_setting,
    overlap_exposure_floor,
    readout_remaining,
    roll_min_interval,
    line_pick,
    line_driver_choice,
    line_direction,
    frame_wait_flag,
    acq_wait_flag,
    frame_overtrigger,
    acq_overtrigger,
    frame_accepted,
    acq_accepted,
    output_one,
    bidir_line_two_out,
    bidir_line_two_oe,
    bidir_line_three_out,
    bidir_line_three_oe
);
    input wire clk;
    input wire rst;
    input wire hw_frame_start_pulse; // pin, level
    input wire ext_acq_start_pulse; // pin, level
    input wire frame_hw_trig_en;
    input wire acq_hw_trig_en;
    input wire acq_active; // acquisition running
    input wire [`TWS_MODE_W-1:0] exposure_mode;
    input wire [`TWS_CW-1:0] exposure_duration_setting; // cycles
    input wire [`TWS_CW-1:0] overlap_exposure_floor; // cycles
    input wire [`TWS_CW-1:0] readout_remaining; // cycles until readout ends
    input wire [`TWS_CW-1:0] roll_min_interval; // cycles
    input wire [`TWS_SEL_W-1:0] line_pick;
    input wire [`TWS_SRC_W-1:0] line_driver_choice;
    input wire line_direction; // 1 = output, for gpio lines
    output reg frame_wait_flag;
    output reg acq_wait_flag;
    output reg frame_overtrigger; // one-cycle pulse
    output reg acq_overtrigger; // one-cycle pulse
    output reg frame_accepted; // one-cycle pulse
    output reg acq_accepted; // one-cycle pulse
    output reg output_one;
    output reg bidir_line_two_out;
    output reg bidir_line_two_oe;
    output reg bidir_line_three_out;
    output reg bidir_line_three_oe;

    localparam ST_IDLE = 3'b001; // no frame triggering possible
    localparam ST_WAIT = 3'b010; // waiting for frame start
    localparam ST_BUSY = 3'b100; // frame in flight, counting down

    wire frame_sync; // synchronised pins
    wire acq_sync;
    reg frame_prev_reg; // edge detect history
    reg acq_prev_reg;
    reg [2:0] state_reg;
    reg [2:0] state_next;
    reg [`TWS_CW-1:0] cnt_reg; // cycles until next wait entry
    reg [`TWS_CW-1:0] cnt_next;
    reg [`TWS_CW-1:0] hold_cnt; // mode-dependent busy time
    reg acq_wait_reg; // internal acquisition waiting status
    wire [`TWS_NLINES-1:0] line_src_val; // selected source level per line
    wire [`TWS_CW:0] roll_sum; // spare top bit, carry dropped on purpose
    reg [`TWS_SRC_W-1:0] line_src_reg [0:`TWS_NLINES-1];
    reg [`TWS_NLINES-1:0] line_dir_reg;

    wire frame_rise = frame_sync & ~frame_prev_reg;
    wire acq_rise = acq_sync & ~acq_prev_reg;
    wire frame_take = frame_rise & (state_reg == ST_WAIT) & frame_hw_trig_en;
    wire acq_take = acq_rise & acq_wait_reg & acq_hw_trig_en;

    // rolling busy time; a sum past 24 bits wraps, users keep settings small
    assign roll_sum = {1'b0, exposure_duration_setting} + {1'b0, roll_min_interval};

    tws_sync2 u_sync_frame (
        .clk(clk),
        .rst(rst),
        .async_in(hw_frame_start_pulse),
        .sync_out(frame_sync)
    );

    tws_sync2 u_sync_acq (
        .clk(clk),
        .rst(rst),
        .async_in(ext_acq_start_pulse),
        .sync_out(acq_sync)
    );

    // busy time picked by exposure mode; overlap lets wait come back
    // before readout fully ends, so width mode subtracts the floor we can hide
    always @* begin
        hold_cnt = `TWS_CNT_ONE;
        case (exposure_mode)
            `TWS_MODE_TIMED: begin
                if (readout_remaining > exposure_duration_setting) begin
                    hold_cnt = readout_remaining;
                end else begin
                    hold_cnt = exposure_duration_setting;
                end
            end
            `TWS_MODE_WIDTH: begin
                // floor is the shortest exposure, pulse covers the rest
                if (readout_remaining > overlap_exposure_floor) begin
                    hold_cnt = readout_remaining - overlap_exposure_floor;
                end else begin
                    hold_cnt = `TWS_CNT_ONE;
                end
            end
            `TWS_MODE_ROLL: begin
                hold_cnt = roll_sum[`TWS_CW-1:0];
            end
            default: begin
                hold_cnt = `TWS_CNT_ONE;
            end
        endcase
        if (hold_cnt == `TWS_CNT_ZERO) begin
            hold_cnt = `TWS_CNT_ONE; // never shorter than one cycle
        end
    end

    // frame status machine
    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            ST_IDLE: begin
                if (frame_hw_trig_en && acq_active) begin
                    state_next = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!frame_hw_trig_en || !acq_active) begin
                    state_next = ST_IDLE;
                end else if (frame_take) begin
                    state_next = ST_BUSY;
                    cnt_next = hold_cnt;
                end
            end
            ST_BUSY: begin
                if (!frame_hw_trig_en || !acq_active) begin
                    state_next = ST_IDLE;
                end else if (cnt_reg <= `TWS_CNT_ONE) begin
                    state_next = ST_WAIT;
                    cnt_next = `TWS_CNT_ZERO;
                end else begin
                    cnt_next = cnt_reg - `TWS_CNT_ONE;
                end
            end
            default: begin
                state_next = ST_IDLE;
                cnt_next = `TWS_CNT_ZERO;
            end
        endcase
    end

    // state, edge history and event pulses
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            cnt_reg <= `TWS_CNT_ZERO;
            frame_prev_reg <= 1'b0;
            acq_prev_reg <= 1'b0;
            acq_wait_reg <= 1'b0;
            frame_overtrigger <= 1'b0;
            acq_overtrigger <= 1'b0;
            frame_accepted <= 1'b0;
            acq_accepted <= 1'b0;
            frame_wait_flag <= 1'b0;
            acq_wait_flag <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            frame_prev_reg <= frame_sync;
            acq_prev_reg <= acq_sync;
            // acquisition waits while enabled and not yet running
            if (!acq_hw_trig_en) begin
                acq_wait_reg <= 1'b0;
            end else if (acq_take) begin
                acq_wait_reg <= 1'b0;
            end else begin
                acq_wait_reg <= ~acq_active;
            end
            frame_accepted <= frame_take;
            acq_accepted <= acq_take;
            frame_overtrigger <= frame_rise & frame_hw_trig_en & ~frame_take;
            acq_overtrigger <= acq_rise & acq_hw_trig_en & ~acq_take;
            frame_wait_flag <= (state_next == ST_WAIT) & frame_hw_trig_en;
            acq_wait_flag <= acq_hw_trig_en & ~acq_take & ~acq_active;
        end
    end

    // per-line source and direction config, written for the picked line
    genvar gi;
    generate
        for (gi = 0; gi < `TWS_NLINES; gi = gi + 1) begin : g_line
            always @(posedge clk or posedge rst) begin
                if (rst) begin
                    line_src_reg[gi] <= `TWS_SRC_LOW;
                    line_dir_reg[gi] <= 1'b0;
                end else if ({{(32 - `TWS_SEL_W){1'b0}}, line_pick} == gi) begin
                    line_src_reg[gi] <= line_driver_choice;
                    line_dir_reg[gi] <= (gi == 0) ? 1'b1 : line_direction;
                end
            end
            // one driver per bit; reserved source codes give a low level
            assign line_src_val[gi] = (line_src_reg[gi] == `TWS_SRC_ACQ) ? acq_wait_flag :
                ((line_src_reg[gi] == `TWS_SRC_FRAME) ? frame_wait_flag : 1'b0);
        end
    endgenerate

    // registered line drivers; gpio lines drive only as outputs
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            output_one <= 1'b0;
            bidir_line_two_out <= 1'b0;
            bidir_line_two_oe <= 1'b0;
            bidir_line_three_out <= 1'b0;
            bidir_line_three_oe <= 1'b0;
        end else begin
            output_one <= line_src_val[0];
            bidir_line_two_out <= line_src_val[1] & line_dir_reg[1];
            bidir_line_two_oe <= line_dir_reg[1];
            bidir_line_three_out <= line_src_val[2] & line_dir_reg[2];
            bidir_line_three_oe <= line_dir_reg[2];
        end
    end
endmodule // tws_trigger_wait

/* File: shared/tws_defines.vh */
// constants for the trigger wait signal generator
`ifndef TWS_DEFINES_VH
`define TWS_DEFINES_VH
`define TWS_CW 24
`define TWS_CNT_ZERO 24'h000000
`define TWS_CNT_ONE 24'h000001
`define TWS_MODE_W 2
`define TWS_MODE_TIMED 2'h0
`define TWS_MODE_WIDTH 2'h1
`define TWS_MODE_ROLL 2'h2
`define TWS_SRC_W 2
`define TWS_SRC_LOW 2'h0
`define TWS_SRC_ACQ 2'h1
`define TWS_SRC_FRAME 2'h2
`define TWS_SEL_W 2
`define TWS_SEL_OUT_ONE 2'h0
`define TWS_SEL_LINE_TWO 2'h1
`define TWS_SEL_LINE_THREE 2'h2
`define TWS_NLINES 3
`endif

/* File: src/tws_sync2.v */
// two-flop synchroniser for one pin input
`timescale 1ns/10ps
module tws_sync2 (
    clk,
    rst,
    async_in,
    sync_out
);
    input wire clk;
    input wire rst;
    input wire async_in;
    output reg sync_out;
    reg meta_reg; // first stage, read only by second stage

    // plain double register, no logic between stages
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            meta_reg <= 1'b0;
            sync_out <= 1'b0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end
endmodule // tws_sync2

/* File: testbench/tws_chk.sv */
// port assertions for the trigger wait generator
`timescale 1ns/10ps
`include "tws_defines.vh"
module tws_chk (
    input wire clk,
    input wire rst,
    input wire frame_hw_trig_en,
    input wire acq_hw_trig_en,
    input wire acq_active,
    input wire [`TWS_SEL_W-1:0] line_pick,
    input wire [`TWS_SRC_W-1:0] line_driver_choice,
    input wire line_direction,
    input wire frame_wait_flag,
    input wire acq_wait_flag,
    input wire frame_overtrigger,
    input wire acq_overtrigger,
    input wire frame_accepted,
    input wire acq_accepted,
    input wire output_one,
    input wire bidir_line_three_out,
    input wire bidir_line_three_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    a_frame_accept_fall: assert property (frame_accepted |-> $past(frame_wait_flag) && !frame_wait_flag)
        else $error("frame accept outside wait");
    a_frame_ovt_busy: assert property (frame_overtrigger |-> !$past(frame_wait_flag))
        else $error("frame overtrigger while waiting");
    a_frame_rise_en: assert property ($rose(frame_wait_flag) |-> $past(frame_hw_trig_en) && $past(acq_active))
        else $error("frame wait rose while not allowed");
    a_frame_pulse_once: assert property (frame_accepted |-> !frame_overtrigger ##1 !frame_accepted)
        else $error("frame accept pulse too long");
    a_acq_accept_fall: assert property (acq_accepted |-> $past(acq_wait_flag) && !acq_wait_flag)
        else $error("acq accept outside wait");
    a_acq_ovt_busy: assert property (acq_overtrigger |-> !$past(acq_wait_flag))
        else $error("acq overtrigger while waiting");
    a_acq_rise_en: assert property ($rose(acq_wait_flag) |-> $past(acq_hw_trig_en) && !$past(acq_active))
        else $error("acq wait rose while not allowed");
    // line config lands one edge before the line output, so the pick is looked at two edges back
    a_line_one_frame: assert property ((!$past(rst) && !$past(rst, 2) &&
        $past(line_pick, 2) == `TWS_SEL_OUT_ONE && $past(line_driver_choice, 2) == `TWS_SRC_FRAME)
        |-> output_one == $past(frame_wait_flag))
        else $error("line one not following frame wait");
    a_line_three_acq: assert property ((!$past(rst) && !$past(rst, 2) &&
        $past(line_pick, 2) == `TWS_SEL_LINE_THREE && $past(line_driver_choice, 2) == `TWS_SRC_ACQ)
        |-> bidir_line_three_oe == $past(line_direction, 2) &&
        (bidir_line_three_out & bidir_line_three_oe) == ($past(acq_wait_flag) & $past(line_direction, 2)))
        else $error("line three not following acq wait");
    c_frame_acc: cover property (frame_accepted);
    c_frame_ovt: cover property (frame_overtrigger);
    c_acq_acc: cover property (acq_accepted);
    c_acq_ovt: cover property (acq_overtrigger);
endmodule // tws_chk
bind tws_trigger_wait tws_chk tws_chk_inst (.*);

/* File: testbench/tws_trig_src.sv */
// external frame trigger source that watches the wait flag
`timescale 1ns/10ps
module tws_trig_src (
    input wire clk,
    input wire rst,
    input wire fire, // one-cycle request
    input wire early, // commanded fault: ignore the flag
    input wire frame_wait_flag,
    input wire [23:0] width, // pulse length in cycles
    output reg pulse
);
    reg [23:0] left_reg; // cycles still to hold
    // a request while the flag is low and early is clear is dropped, never queued
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            pulse <= 1'b0;
            left_reg <= 24'h000000;
        end else if (left_reg != 24'h000000) begin
            left_reg <= left_reg - 24'h000001;
            pulse <= (left_reg != 24'h000001);
        end else if (fire && (frame_wait_flag || early)) begin
            pulse <= 1'b1;
            left_reg <= width;
        end
    end
endmodule // tws_trig_src

/* File: testbench/testbench.sv */
// self-checking bench for the trigger wait generator
`timescale 1ns/10ps
`include "tws_defines.vh"
module testbench;
    reg clk = 1'b0; // 8 ns period
    reg rst = 1'b1;
    reg ext_acq_start_pulse = 1'b0, frame_hw_trig_en = 1'b1, acq_hw_trig_en = 1'b0, acq_active = 1'b1;
    reg line_direction = 1'b1, fire = 1'b0, early = 1'b0, ex = 1'b0;
    reg [1:0] exposure_mode = 2'h0, line_pick = 2'h0, line_driver_choice = 2'h0;
    reg [23:0] exposure_duration_setting = 24'h000000, overlap_exposure_floor = 24'h000000;
    reg [23:0] readout_remaining = 24'h000000, roll_min_interval = 24'h000000;
    reg [39:0] rw [0:4]; // mode, exposure, floor, readout, expected hold
    wire hw_frame_start_pulse, frame_wait_flag, acq_wait_flag, frame_overtrigger, acq_overtrigger;
    wire frame_accepted, acq_accepted, output_one, bidir_line_two_out, bidir_line_two_oe;
    wire bidir_line_three_out, bidir_line_three_oe;
    integer n_mismatch = 0, n_tests = 0, n_facc = 0, n_fovt = 0, n_aacc = 0, n_aovt = 0, i, k, c, b;
    always #4 clk = ~clk;
    tws_trigger_wait tws_trigger_wait_inst (.*);
    tws_trig_src tws_trig_src_inst (.clk, .rst, .fire, .early, .frame_wait_flag,
        .width(overlap_exposure_floor + 24'h000002), .pulse(hw_frame_start_pulse));
    // tally one-cycle pulses
    always @(posedge clk) begin
        n_facc = n_facc + (frame_accepted === 1'b1);
        n_fovt = n_fovt + (frame_overtrigger === 1'b1);
        n_aacc = n_aacc + (acq_accepted === 1'b1);
        n_aovt = n_aovt + (acq_overtrigger === 1'b1);
    end
    task step(input integer n); // inputs move 1 ns after the edge
        repeat (n) @(posedge clk);
        #1;
    endtask
    task chk_v(input [63:0] nm, input [31:0] e, input [31:0] g);
        n_tests = n_tests + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("unexpected %0s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task chk_b(input [63:0] nm, input e, input g);
        chk_v(nm, {31'h0, e}, {31'h0, g});
    endtask
    task wait_fw; // bounded wait for frame wait
        c = 0;
        while (frame_wait_flag !== 1'b1 && c < 400) begin
            step(1);
            c = c + 1;
        end
    endtask
    task shoot; // one request to the trigger source
        fire = 1'b1;
        step(1);
        fire = 1'b0;
    endtask
    task acq_pin; // acquisition pin pulse, three cycles wide
        ext_acq_start_pulse = 1'b1;
        step(3);
        ext_acq_start_pulse = 1'b0;
    endtask
    task print_verdict;
        $display("compares %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // run needs about 900 cycles; about fourteen times that before giving up
    initial begin
        #100000;
        n_mismatch = n_mismatch + 1;
        print_verdict;
    end
    initial begin
        rw[0] = 40'h0014001E1E;
        rw[1] = 40'h0028000A28;
        rw[2] = 40'h01000F2819;
        rw[3] = 40'h0100320A01;
        rw[4] = 40'h020C000814;
        step(6);
        rst = 1'b0;
        // hold time per exposure mode
        for (i = 0; i < 5; i = i + 1) begin
            exposure_mode = rw[i][33:32];
            exposure_duration_setting = {16'h0000, rw[i][31:24]};
            overlap_exposure_floor = {16'h0000, rw[i][23:16]};
            readout_remaining = {16'h0000, rw[i][15:8]};
            roll_min_interval = readout_remaining;
            step(60);
            wait_fw;
            chk_b("fw_up", 1'b1, frame_wait_flag);
            shoot;
            c = 0;
            while (frame_accepted !== 1'b1 && c < 20) begin
                step(1);
                c = c + 1;
            end
            chk_b("fw_drop", 1'b0, frame_wait_flag);
            wait_fw;
            chk_v("hold", {24'h000000, rw[i][7:0]}, c);
            $display("row %0d done", i);
        end
        // trigger while busy is refused
        exposure_mode = `TWS_MODE_TIMED;
        readout_remaining = 24'h00001E;
        step(60);
        b = n_facc;
        k = n_fovt;
        shoot;
        step(10);
        early = 1'b1;
        shoot;
        early = 1'b0;
        step(10);
        chk_v("acc_n", b + 1, n_facc);
        chk_v("ovt_n", k + 1, n_fovt);
        frame_hw_trig_en = 1'b0;
        step(4);
        chk_b("fw_off", 1'b0, frame_wait_flag);
        frame_hw_trig_en = 1'b1;
        $display("frame refusal done");
        // acquisition wait, accept and refusal
        acq_active = 1'b0;
        step(4);
        chk_b("aw_off", 1'b0, acq_wait_flag);
        acq_hw_trig_en = 1'b1;
        step(4);
        chk_b("aw_up", 1'b1, acq_wait_flag);
        b = n_aacc;
        k = n_aovt;
        acq_pin;
        acq_active = 1'b1;
        step(4);
        chk_b("aw_drop", 1'b0, acq_wait_flag);
        acq_pin;
        step(6);
        chk_v("aacc_n", b + 1, n_aacc);
        chk_v("aovt_n", k + 1, n_aovt);
        $display("acquisition done");
        // every line, source and direction
        for (k = 0; k < 4; k = k + 1) begin
            acq_active = k[0];
            line_direction = k[1];
            step(60);
            for (i = 0; i < 16; i = i + 1) begin
                if (i[3:2] != 2'h3 && i[1:0] != 2'h3) begin
                    line_pick = i[3:2];
                    line_driver_choice = i[1:0];
                    ex = (i[1:0] == `TWS_SRC_ACQ) ? !k[0] : (i[1:0] == `TWS_SRC_FRAME) & k[0];
                    step(3);
                    if (line_pick == `TWS_SEL_OUT_ONE)
                        chk_b("out_one", ex, output_one);
                    else if (line_pick == `TWS_SEL_LINE_TWO)
                        chk_v("ln_two", {line_direction, ex & line_direction},
                            {bidir_line_two_oe, bidir_line_two_out & bidir_line_two_oe});
                    else
                        chk_v("ln_three", {line_direction, ex & line_direction},
                            {bidir_line_three_oe, bidir_line_three_out & bidir_line_three_oe});
                end
            end
        end
        $display("routing done");
        rst = 1'b1;
        step(1);
        chk_b("rst_low", 1'b0, frame_wait_flag | acq_wait_flag);
        rst = 1'b0;
        $display("reset done");
        print_verdict;
    end
endmodule // testbench
